//--- pcrbc_pkg.sv
// Constants, field layout and carrier types for the power control registers.
// Assumes a 100 MHz core clock and oscillators far slower than it.
`default_nettype none

package pcrbc_pkg;

  localparam int unsigned ADDR_W = 17;
  localparam int unsigned IDX_W = 15;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_BOOSTER_CLOCK_CTRL = 15'h5071;
  localparam logic [IDX_W-1:0] IDX_DISPLAY_REGULATOR_CTRL = 15'h50a3;
  localparam logic [IDX_W-1:0] IDX_CORE_REGULATOR_CTRL = 15'h5120;

  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Writable bits; all others are reserved and stay zero
  localparam logic [7:0] BCLK_WMASK = 8'h7d;
  localparam logic [7:0] VREG_WMASK = 8'h11;
  localparam logic [7:0] CORE_WMASK = 8'h20;

  localparam int unsigned DIV_LSB = 4;
  localparam int unsigned SRC_LSB = 2;
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned VREG_HEAVY_BIT = 4;
  localparam int unsigned VREG_REF_BIT = 0;
  localparam int unsigned CORE_HEAVY_BIT = 5;

  localparam logic [1:0] SRC_OSC_B = 2'h0;
  localparam logic [1:0] SRC_LOW = 2'h1;
  localparam logic [1:0] SRC_OSC_A = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;

  localparam logic [2:0] DIV_MAX_OSC = 3'h6;
  localparam logic [2:0] DIV_MAX_LOW = 3'h3;

  // Half of the code-0 ratio, in source edges
  localparam int unsigned CNT_W = 13;
  localparam logic [CNT_W-1:0] HALF_OSC_B = 13'h0020;
  localparam logic [CNT_W-1:0] HALF_OSC_A = 13'h0040;
  localparam logic [CNT_W-1:0] HALF_LOW = 13'h0004;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } pcrbc_bus_state_t;

  typedef struct packed {
    logic [2:0] div;
    logic [1:0] src;
    logic en;
  } pcrbc_bclk_cfg_t;

  typedef struct packed {
    logic display_reg_heavy_load;
    logic ref_volt_sel;
    logic core_reg_heavy_load;
  } pcrbc_reg_out_t;

endpackage : pcrbc_pkg

`default_nettype wire

//--- pcrbc_sync.sv
// Two-flop synchronisers and rise detectors for the three oscillator pins.
// Assumes each oscillator is much slower than core_clk.
`timescale 1ns/1ps
`default_nettype none

module pcrbc_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [2:0] osc_in,
  output logic [2:0] osc_rise
);
  import pcrbc_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      // Per-bit flops, so each variable has a single driving process
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic s1_next;
      logic s2_next;
      logic s3_next;
      always_comb begin
        s1_next = osc_in[i];
        s2_next = s1_reg;
        s3_next = s2_reg;
      end
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= s1_next;
          s2_reg <= s2_next;
          s3_reg <= s3_next;
        end
      end
      // Edge detector reads only the second and third flops
      assign osc_rise[i] = s2_reg & ~s3_reg;
    end
  endgenerate

endmodule : pcrbc_sync

`default_nettype wire

//--- pcrbc_divider.sv
// Booster clock divider counting rising edges of the selected oscillator.
// Assumes one-cycle rise pulses per oscillator from the synchroniser.
`timescale 1ns/1ps
`default_nettype none

module pcrbc_divider (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire pcrbc_pkg::pcrbc_bclk_cfg_t cfg,
  input wire logic [2:0] osc_rise,
  output logic booster_clk
);
  import pcrbc_pkg::*;

  pcrbc_bclk_cfg_t act_reg, act_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic out_reg, out_next;
  logic [CNT_W-1:0] half;
  logic legal;
  logic edge_in;

  always_comb begin
    edge_in = 1'b0;
    half = HALF_OSC_B;
    legal = 1'b0;
    unique case (act_reg.src)
      SRC_OSC_B: begin
        edge_in = osc_rise[0];
        half = HALF_OSC_B << act_reg.div;
        legal = act_reg.div <= DIV_MAX_OSC;
      end
      SRC_LOW: begin
        edge_in = osc_rise[1];
        half = HALF_LOW << act_reg.div;
        legal = act_reg.div <= DIV_MAX_LOW;
      end
      SRC_OSC_A: begin
        edge_in = osc_rise[2];
        half = HALF_OSC_A << act_reg.div;
        legal = act_reg.div <= DIV_MAX_OSC;
      end
      SRC_RSVD: begin
        legal = 1'b0;
      end
    endcase
    legal = legal & act_reg.en;
  end

  // Settings load at a fall, or at once while low; restarting a low
  // half only lengthens it, so a disable stops the clock without a
  // short pulse and a stale long setting never lingers
  always_comb begin
    act_next = act_reg;
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (!out_reg && (!legal || cfg != act_reg)) begin
      act_next = cfg;
      cnt_next = '0;
    end else if (edge_in) begin
      if (cnt_reg == half - 13'h0001) begin
        cnt_next = '0;
        if (out_reg) begin
          out_next = 1'b0;
          act_next = cfg;
        end else begin
          out_next = 1'b1;
        end
      end else begin
        cnt_next = cnt_reg + 13'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      act_reg <= '0;
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      act_reg <= act_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign booster_clk = out_reg;

  a_off_stays_low: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!out_reg && !act_reg.en) |=> !out_reg)
    else $error("booster clock rose while disabled");
  a_half_whole: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(out_reg) |-> $past(cnt_reg) == $past(half) - 13'h0001)
    else $error("booster high half cut short");
  a_rsvd_src_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!out_reg && act_reg.src == SRC_RSVD) |=> !out_reg)
    else $error("booster clock ran on reserved source");

endmodule : pcrbc_divider

`default_nettype wire

//--- pcrbc_top.sv
// Power control register bank with booster clock generation.
// Assumes an Avalon-MM master with byte addresses and oscillator pins
// asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module pcrbc_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [pcrbc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  input wire logic internal_osc_b,
  input wire logic low_speed_osc,
  input wire logic osc_a_high,
  output logic booster_clk,
  output pcrbc_pkg::pcrbc_reg_out_t reg_ctl
);
  import pcrbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave

  pcrbc_bus_state_t state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] resp_reg, resp_next;
  logic [IDX_W-1:0] idx;
  logic sel_bclk;
  logic sel_vreg;
  logic sel_core;
  logic req;
  logic wr_fire;

  logic [7:0] bclk_reg, bclk_next;
  logic [7:0] vreg_reg, vreg_next;
  logic [7:0] core_reg, core_next;

  assign idx = avs_address[ADDR_W-1:2];
  assign req = avs_read | avs_write;

  always_comb begin
    sel_bclk = idx == IDX_BOOSTER_CLOCK_CTRL;
    sel_vreg = idx == IDX_DISPLAY_REGULATOR_CTRL;
    sel_core = idx == IDX_CORE_REGULATOR_CTRL;
  end

  // One wait cycle per access; answer registered for a clean readdata
  always_comb begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    resp_next = resp_reg;
    unique case (state_reg)
      BUS_IDLE: begin
        if (req) begin
          state_next = BUS_ACK;
          resp_next = (sel_bclk | sel_vreg | sel_core) ?
                      RESP_OKAY : RESP_SLVERR;
          rdata_next = '0;
          if (avs_read && sel_bclk) begin
            rdata_next[7:0] = bclk_reg;
          end else if (avs_read && sel_vreg) begin
            rdata_next[7:0] = vreg_reg;
          end else if (avs_read && sel_core) begin
            rdata_next[7:0] = core_reg;
          end
        end
      end
      BUS_ACK: begin
        state_next = BUS_IDLE;
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= BUS_IDLE;
      rdata_reg <= '0;
      resp_reg <= RESP_OKAY;
    end else begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      resp_reg <= resp_next;
    end
  end

  assign avs_waitrequest = req && (state_reg != BUS_ACK);
  assign avs_readdata = rdata_reg;
  assign avs_response = resp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  // A write lands at the edge that completes the access
  assign wr_fire = (state_reg == BUS_ACK) && avs_write && avs_byteenable[0];

  always_comb begin
    bclk_next = bclk_reg;
    vreg_next = vreg_reg;
    core_next = core_reg;
    if (wr_fire && sel_bclk) begin
      bclk_next = avs_writedata[7:0] & BCLK_WMASK;
    end
    if (wr_fire && sel_vreg) begin
      vreg_next = avs_writedata[7:0] & VREG_WMASK;
    end
    if (wr_fire && sel_core) begin
      core_next = avs_writedata[7:0] & CORE_WMASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bclk_reg <= RESET_VALUE;
      vreg_reg <= RESET_VALUE;
      core_reg <= RESET_VALUE;
    end else begin
      bclk_reg <= bclk_next;
      vreg_reg <= vreg_next;
      core_reg <= core_next;
    end
  end

  always_comb begin
    reg_ctl.display_reg_heavy_load = vreg_reg[VREG_HEAVY_BIT];
    reg_ctl.ref_volt_sel = vreg_reg[VREG_REF_BIT];
    reg_ctl.core_reg_heavy_load = core_reg[CORE_HEAVY_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Booster clock

  pcrbc_bclk_cfg_t bclk_cfg;
  logic [2:0] osc_rise;

  always_comb begin
    bclk_cfg.div = bclk_reg[DIV_LSB +: 3];
    bclk_cfg.src = bclk_reg[SRC_LSB +: 2];
    bclk_cfg.en = bclk_reg[EN_BIT];
  end

  // Oscillators are only sampled; slow enough for plain edge counting
  pcrbc_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .osc_in({osc_a_high, low_speed_osc, internal_osc_b}),
    .osc_rise(osc_rise)
  );

  pcrbc_divider u_div (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cfg(bclk_cfg),
    .osc_rise(osc_rise),
    .booster_clk(booster_clk)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic acc_done;
  assign acc_done = (state_reg == BUS_ACK) && req;

  a_read_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    acc_done |-> (avs_readdata[31:8] == 24'h000000 &&
                  avs_readdata[1] == 1'b0 && avs_readdata[7] == 1'b0))
    else $error("reserved read bits not zero");
  a_wait_one: assert property (@(posedge core_clk) disable iff (!rst_b)
    (req && state_reg == BUS_IDLE) |-> avs_waitrequest ##1
    (!avs_waitrequest || !req))
    else $error("access not answered after one wait cycle");
  a_unmapped_err: assert property (@(posedge core_clk) disable iff (!rst_b)
    (acc_done && !(sel_bclk || sel_vreg || sel_core)) |->
    (avs_response == RESP_SLVERR && avs_readdata == 32'h00000000))
    else $error("unmapped access not refused");
  a_bclk_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_fire && sel_bclk) |=>
    (bclk_cfg.div == $past(avs_writedata[6:4]) &&
     bclk_cfg.src == $past(avs_writedata[3:2]) &&
     bclk_cfg.en == $past(avs_writedata[0])))
    else $error("booster control write lost");
  a_ref_sel: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_fire && sel_vreg) |=>
    (reg_ctl.ref_volt_sel == $past(avs_writedata[0]) &&
     reg_ctl.display_reg_heavy_load == $past(avs_writedata[4])))
    else $error("display regulator outputs wrong");
  a_core_heavy: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_fire && sel_core) |=>
    reg_ctl.core_reg_heavy_load == $past(avs_writedata[5]))
    else $error("core heavy-load output wrong");
  a_reset_values: assert property (@(posedge core_clk)
    !rst_b |=> (bclk_reg == 8'h00 && !reg_ctl.display_reg_heavy_load &&
               !reg_ctl.core_reg_heavy_load && !booster_clk))
    else $error("registers not cleared by reset");
  a_disabled_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!bclk_cfg.en && !booster_clk) [*2] |=> !booster_clk)
    else $error("booster clock runs while disabled");
  a_no_write_on_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    (acc_done && avs_read) |=> $stable(bclk_reg) && $stable(core_reg))
    else $error("read altered a register");

  c_enable_write: cover property (@(posedge core_clk) disable iff (!rst_b)
    wr_fire && sel_bclk && avs_writedata[0]);
  c_booster_runs: cover property (@(posedge core_clk) disable iff (!rst_b)
    $rose(booster_clk));
  c_unmapped: cover property (@(posedge core_clk) disable iff (!rst_b)
    acc_done && avs_response == RESP_SLVERR);
  c_heavy_on: cover property (@(posedge core_clk) disable iff (!rst_b)
    reg_ctl.core_reg_heavy_load && reg_ctl.display_reg_heavy_load);

endmodule : pcrbc_top

`default_nettype wire

//--- tb_power_ctrl_regs_booster_clk.sv
// Self-checking bench for the power control register bank and booster clock.
// Assumes the bench alone drives the Avalon-MM port and the oscillator pins.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end

module tb_power_ctrl_regs_booster_clk;
  import pcrbc_pkg::*;

  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic [1:0] avs_response;
  logic avs_waitrequest;
  logic [2:0] osc = '0;
  logic booster_clk;
  pcrbc_reg_out_t reg_ctl;
  int mismatches = 0;
  int checked = 0;
  int osc_cnt [3] = '{0, 0, 0};
  logic [7:0] model [3] = '{8'h00, 8'h00, 8'h00};

  // Distinct oscillator periods, so a swapped source gives a wrong length
  localparam int OSC_HALF [3] = '{4, 5, 6};
  localparam int BASE_RATIO [3] = '{64, 8, 128};
  localparam logic [7:0] WMASK [3] = '{8'h7d, 8'h11, 8'h20};
  localparam logic [ADDR_W-1:0] ADDR_TAB [4] = '{{15'h5071, 2'b00},
    {15'h50a3, 2'b00}, {15'h5120, 2'b00}, {15'h5072, 2'b00}};
  // Disabled, reserved source, reserved ratio codes
  localparam logic [7:0] STOP_CFG [4] = '{8'h00, 8'h0d, 8'h71, 8'h45};

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (osc_cnt[k] == OSC_HALF[k] - 1) begin
        osc_cnt[k] <= 0;
        osc[k] <= ~osc[k];
      end else begin
        osc_cnt[k] <= osc_cnt[k] + 1;
      end
    end
  end

  pcrbc_top pcrbc_top_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest),
    .internal_osc_b(osc[0]),
    .low_speed_osc(osc[1]),
    .osc_a_high(osc[2]),
    .booster_clk(booster_clk),
    .reg_ctl(reg_ctl)
  );

  ////////////////////////////////////////////////////////////////////////////

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // Entered just after a rising edge; ends one idle edge after completion
  task automatic bus_op(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] rd,
    output logic [1:0] rs);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      $display("FAIL %0t bus answer missing", $time);
      close_out();
    end
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus_op

  task automatic do_write(input int r, input logic [7:0] d,
    input logic [3:0] be);
    logic [31:0] rd;
    logic [1:0] rs;
    bus_op(1'b1, ADDR_TAB[r] | 17'($urandom_range(0, 3)),
      {24'($urandom), d}, be, rd, rs);
    `CHK(rs, (r < 3) ? RESP_OKAY : RESP_SLVERR)
    if (r < 3 && be[0]) begin
      model[r] = d & WMASK[r];
    end
  endtask : do_write

  task automatic do_read(input int r);
    logic [31:0] rd;
    logic [1:0] rs;
    bus_op(1'b0, ADDR_TAB[r], 32'h0, 4'hf, rd, rs);
    `CHK(rd, (r < 3) ? {24'h0, model[r]} : 32'h0)
    `CHK(rs, (r < 3) ? RESP_OKAY : RESP_SLVERR)
  endtask : do_read

  task automatic wait_clk(input logic v);
    int n;
    n = 0;
    while (booster_clk !== v && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    if (booster_clk !== v) begin
      mismatches++;
      $display("FAIL %0t booster clock stuck", $time);
      close_out();
    end
  endtask : wait_clk

  task automatic run_len(input logic v, input int lim, output int n);
    n = 0;
    while (booster_clk === v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask : run_len

  ////////////////////////////////////////////////////////////////////////////

  initial begin
    int hi;
    int lo;
    int exp_half;
    logic [7:0] cfg;
    pcrbc_reg_out_t exp_ctl;
    void'($urandom(32'h298c));
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    `CHK(booster_clk, 1'b0)
    `CHK(reg_ctl, pcrbc_reg_out_t'(3'h0))
    for (int r = 0; r < 4; r++) begin
      do_read(r);
    end
    $display("Test reset values done");

    // Random data sets reserved bits on purpose; they must not stick
    repeat (40) begin
      int r;
      r = $urandom_range(0, 3);
      do_write(r, 8'($urandom), 4'($urandom));
      exp_ctl = pcrbc_reg_out_t'({model[1][4], model[1][0], model[2][5]});
      `CHK(reg_ctl, exp_ctl)
      do_read(r);
    end
    $display("Test random access done");

    // The first high after a write may still use the old setting
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 4; c++) begin
        cfg = {1'b0, 3'(c), 2'(s), 2'b01};
        do_write(0, cfg, 4'h1);
        wait_clk(1'b1);
        wait_clk(1'b0);
        wait_clk(1'b1);
        run_len(1'b1, 20000, hi);
        run_len(1'b0, 20000, lo);
        exp_half = (BASE_RATIO[s] << c) * OSC_HALF[s];
        `CHK(hi, exp_half)
        `CHK(lo, exp_half)
      end
    end
    $display("Test booster ratios done");

    for (int k = 0; k < 4; k++) begin
      do_write(0, 8'h05, 4'h1);
      wait_clk(1'b1);
      do_write(0, STOP_CFG[k], 4'h1);
      wait_clk(1'b0);
      run_len(1'b0, 1500, lo);
      `CHK(lo, 1500)
    end
    $display("Test booster stop done");

    // Leave every regulator in its low-current state at the end
    do_write(1, 8'h00, 4'h1);
    do_write(2, 8'h00, 4'h1);
    exp_ctl = pcrbc_reg_out_t'(3'h0);
    `CHK(reg_ctl, exp_ctl)
    do_write(0, 8'h00, 4'h1);
    do_read(0);
    $display("Test settle done");
    close_out();
  end

endmodule : tb_power_ctrl_regs_booster_clk

`default_nettype wire
